// [design/sqh_request_handler.sv]
// request queue command handler: header parser, dispatch and completion
// Notes on behaviour
// - completion goes back on the queue the request came from; no cross-queue order
// - unit address C1 01 then six zeros selects the unit-list well-known unit
// - ordinary address: 1, target, single-level unit, four zero bytes
// - every task attribute is handled as simple
// - implicit head-of-queue commands may ignore attribute; driver avoids ordered (the bench still sends ordered on one random command)
// - command reference number is an 8-bit unsigned value
// - command descriptor length follows the configured descriptor size
// - protection sizes and outgoing bytes parsed only when negotiated
// - sense length reports bytes actually stored in the sense buffer
// - residual is requested length minus bytes moved both ways
// - residual below data-in size means data-out fully consumed
// - status byte carries the target's standard status code
// - OK response whenever completed with valid status, good or not
// - overrun when the command needs more than both buffers hold
// - aborted response for requests cancelled by abort functions
// - reset response for requests cancelled by bus or device reset
// - bad-target response, unprocessed, when the target does not exist
// - transport-failure response, code 6, on a broken link
// - target, nexus and busy failures pass through as reported
// - generic failure, code 9; at once for bidirectional without feature
// - outstanding commands complete before reset, with failure unless aborted
// - feature bit 0 allows both data directions in one request
// - feature bit 3 adds protection fields to the header
// - sense size returns to 96 on reset
// - descriptor size returns to 32 on reset
`include "sqh_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module sqh_request_handler (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic reqValid,
  input wire logic [7:0] reqData,
  input wire logic reqLast,
  input wire logic [3:0] reqQueue,
  input wire logic [31:0] reqInLen,
  output logic reqReady,
  output logic exeStart,
  output logic exeWellKnown,
  output logic [7:0] exeTarget,
  output logic [13:0] exeLun,
  output logic [7:0] exeCrn,
  output logic [31:0] outgoingProtectionLength,
  output logic [31:0] incomingProtectionLength,
  output logic [31:0] exeDataOutLen,
  output logic [31:0] exeDataInLen,
  input wire logic [4:0] cdbRdIdx,
  output logic [7:0] cdbRdByte,
  input wire logic tgtDone,
  input wire logic [3:0] tgtResult,
  input wire logic [7:0] tgtStatus,
  input wire logic [31:0] tgtSenseLen,
  input wire logic [31:0] tgtNeed,
  input wire logic [31:0] tgtXfer,
  input wire logic cancelAbort,
  input wire logic cancelReset,
  input wire logic devDrain,
  output logic drainDone,
  input wire logic cmpReady,
  output logic cmpValid,
  output logic [3:0] cmpQueue,
  output logic [63:0] cmpTag,
  output logic [3:0] cmpResponse,
  output logic [7:0] cmpStatus,
  output logic [31:0] cmpSenseLen,
  output logic [31:0] cmpResidual
);

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  sqh_pkg::sqh_state_e stQ, stD;
  logic [31:0] cntQ, cntD;
  logic [7:0] lunQ [8];
  logic [7:0] cdbQ [`SQH_CDB_DEPTH];
  logic [63:0] tagQ;
  logic [7:0] crnQ;
  logic [3:0] queueQ;
  logic [31:0] outLenQ, inLenQ, doutQ, dinQ;
  logic shortQ, startedQ, startQ;
  logic [3:0] featQ;
  logic [31:0] senseSizeQ, cdbSizeQ;
  logic [7:0] maxTgtQ;
  logic [15:0] cmpCntQ;
  logic waitQ, readyQ, drainDoneQ, validQ;
  logic [31:0] rdDataQ;
  logic [3:0] respQ;
  logic [7:0] statQ;
  logic [31:0] senseQ, residQ;
  logic [7:0] cdbByteQ;

  // parse states accept stream bytes
  function automatic logic isParse(input sqh_pkg::sqh_state_e s);
    isParse = s == sqh_pkg::ST_LUN || s == sqh_pkg::ST_TAG ||
      s == sqh_pkg::ST_ATTR || s == sqh_pkg::ST_CDB ||
      s == sqh_pkg::ST_PILEN || s == sqh_pkg::ST_PIOUT ||
      s == sqh_pkg::ST_DOUT;
  endfunction

  // ----------------------------------------
  // decode of header and outcome
  // ----------------------------------------
  wire take = reqValid && readyQ;
  wire [31:0] cnt1 = cntQ + 32'h1;
  wire featInout = featQ[`SQH_FEAT_INOUT_BIT];
  wire featPi = featQ[`SQH_FEAT_PI_BIT];
  // last header byte: a request with no data-out may end here
  wire headerEnd = (stQ == sqh_pkg::ST_CDB && cnt1 >= cdbSizeQ && !featPi) ||
    (stQ == sqh_pkg::ST_PILEN && cntQ == 32'h7 && outLenQ == 32'h0) ||
    (stQ == sqh_pkg::ST_PIOUT && cnt1 >= outLenQ);
  wire zeroTail = lunQ[4] == 8'h00 && lunQ[5] == 8'h00 &&
    lunQ[6] == 8'h00 && lunQ[7] == 8'h00;
  wire wellKnown = lunQ[0] == `SQH_LUN_WK_B0 &&
    lunQ[1] == `SQH_LUN_WK_B1 && lunQ[2] == 8'h00 &&
    lunQ[3] == 8'h00 && zeroTail;
  wire flatForm = lunQ[0] == `SQH_LUN_FLAT_B0 &&
    lunQ[2][7:6] == `SQH_LUN_SINGLE_LEVEL && zeroTail;
  wire badTarget = !wellKnown &&
    (!flatForm || lunQ[1] > maxTgtQ);
  wire bidiBad = doutQ != 32'h0 && dinQ != 32'h0 && !featInout;
  wire earlyReject = shortQ || bidiBad || badTarget;
  wire [3:0] earlyResp = (shortQ || bidiBad) ? `SQH_RESP_FAILURE :
    `SQH_RESP_BAD_TARGET;
  wire [31:0] bufLen = doutQ + dinQ;
  // a need beyond both buffers beats a clean target result
  wire overrun = tgtNeed > bufLen;
  wire inExec = stQ == sqh_pkg::ST_EXEC;
  wire drainHit = devDrain && (inExec ||
    (isParse(stQ) && !(stQ == sqh_pkg::ST_LUN && cntQ == 32'h0)));
  wire finish = inExec && ((earlyReject && !startedQ) ||
    (startedQ && (tgtDone || cancelAbort || cancelReset)));

  // response priority: resets, aborts, drain, early checks, target
  wire [3:0] respD =
    (cancelReset && startedQ) ? `SQH_RESP_RESET :
    (cancelAbort && startedQ) ? `SQH_RESP_CANCELLED_BY_ABORT :
    drainHit ? `SQH_RESP_FAILURE :
    !startedQ ? earlyResp :
    (tgtResult == `SQH_RESP_OK && overrun) ? `SQH_RESP_OVERRUN :
    tgtResult;
  wire targetRan = startedQ && tgtDone && !cancelAbort &&
    !cancelReset && !drainHit;
  // status only meaningful when the target really answered
  wire [7:0] statD = (targetRan && respD == `SQH_RESP_OK) ?
    tgtStatus : 8'h00;
  // sense beyond the configured size is never stored
  wire [31:0] senseD = !targetRan ? 32'h0 :
    (tgtSenseLen > senseSizeQ) ? senseSizeQ : tgtSenseLen;
  // target moves data-out before data-in, which keeps the residual
  // below data-in size only once data-out is used up
  wire [31:0] residD = !targetRan ? bufLen :
    (tgtXfer > bufLen) ? 32'h0 : bufLen - tgtXfer;

  // ----------------------------------------
  // parser and completion state machine
  // ----------------------------------------
  always_comb begin
    stD = stQ;
    case (stQ)
      sqh_pkg::ST_LUN: begin
        if (take && cntQ == 32'h7) stD = sqh_pkg::ST_TAG;
      end
      sqh_pkg::ST_TAG: begin
        if (take && cntQ == 32'h7) stD = sqh_pkg::ST_ATTR;
      end
      sqh_pkg::ST_ATTR: begin
        if (take && cntQ == 32'h2) stD = sqh_pkg::ST_CDB;
      end
      sqh_pkg::ST_CDB: begin
        if (take && cnt1 >= cdbSizeQ) begin
          stD = featPi ? sqh_pkg::ST_PILEN : sqh_pkg::ST_DOUT;
        end
      end
      sqh_pkg::ST_PILEN: begin
        if (take && cntQ == 32'h7) begin
          stD = (outLenQ != 32'h0) ? sqh_pkg::ST_PIOUT :
            sqh_pkg::ST_DOUT;
        end
      end
      sqh_pkg::ST_PIOUT: begin
        if (take && cnt1 >= outLenQ) stD = sqh_pkg::ST_DOUT;
      end
      sqh_pkg::ST_DOUT: begin
        stD = sqh_pkg::ST_DOUT;
      end
      sqh_pkg::ST_EXEC: begin
        if (finish) stD = sqh_pkg::ST_CMPL;
      end
      sqh_pkg::ST_CMPL: begin
        if (cmpReady) stD = sqh_pkg::ST_LUN;
      end
      default: begin
        stD = sqh_pkg::ST_LUN;
      end
    endcase
    if (take && reqLast && isParse(stQ)) stD = sqh_pkg::ST_EXEC;
    if (drainHit) stD = sqh_pkg::ST_CMPL;
  end

  // byte counter restarts on every state change
  always_comb begin
    cntD = (stD != stQ) ? 32'h0 : (take ? cnt1 : cntQ);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stQ <= sqh_pkg::ST_LUN;
      cntQ <= 32'h0;
    end else begin
      stQ <= stD;
      cntQ <= cntD;
    end
  end

  // ----------------------------------------
  // header capture
  // ----------------------------------------
  // attribute and priority are dropped: all tasks run as simple
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tagQ <= 64'h0;
      crnQ <= 8'h00;
      queueQ <= 4'h0;
    end else if (take) begin
      if (stQ == sqh_pkg::ST_LUN && cntQ == 32'h0) queueQ <= reqQueue;
      if (stQ == sqh_pkg::ST_TAG) tagQ[cntQ[2:0]*8 +: 8] <= reqData;
      if (stQ == sqh_pkg::ST_ATTR && cntQ == 32'h2) crnQ <= reqData;
    end
  end

  // unit address and descriptor bytes
  generate
    for (genvar i = 0; i < 8; i++) begin : gLun
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) lunQ[i] <= 8'h00;
        else if (take && stQ == sqh_pkg::ST_LUN && cntQ == i) lunQ[i] <= reqData;
      end
    end
    for (genvar j = 0; j < `SQH_CDB_DEPTH; j++) begin : gCdb
      // bytes past the storage depth are consumed but not kept
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) cdbQ[j] <= 8'h00;
        else if (take && stQ == sqh_pkg::ST_CDB && cntQ == j) cdbQ[j] <= reqData;
      end
    end
  endgenerate

  // protection sizes, little-endian, then data-out count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      outLenQ <= 32'h0;
      inLenQ <= 32'h0;
      doutQ <= 32'h0;
      dinQ <= 32'h0;
      shortQ <= 1'b0;
    end else if (stQ == sqh_pkg::ST_LUN && cntQ == 32'h0) begin
      outLenQ <= 32'h0;
      inLenQ <= 32'h0;
      doutQ <= 32'h0;
      shortQ <= 1'b0;
    end else if (take) begin
      if (stQ == sqh_pkg::ST_PILEN && !cntQ[2]) begin
        outLenQ[cntQ[1:0]*8 +: 8] <= reqData;
      end
      if (stQ == sqh_pkg::ST_PILEN && cntQ[2]) begin
        inLenQ[cntQ[1:0]*8 +: 8] <= reqData;
      end
      if (stQ == sqh_pkg::ST_DOUT) doutQ <= doutQ + 32'h1;
      if (reqLast) begin
        dinQ <= reqInLen;
        // a stream that ends inside the header after its first byte is rejected
        shortQ <= stQ != sqh_pkg::ST_DOUT && !headerEnd;
      end
    end
  end

  // ----------------------------------------
  // dispatch to the target side
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      startedQ <= 1'b0;
      startQ <= 1'b0;
    end else begin
      startQ <= inExec && !startedQ && !earlyReject && !drainHit;
      if (!inExec) startedQ <= 1'b0;
      else if (!earlyReject) startedQ <= 1'b1;
    end
  end

  // ----------------------------------------
  // completion record
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      validQ <= 1'b0;
      respQ <= `SQH_RESP_OK;
      statQ <= 8'h00;
      senseQ <= 32'h0;
      residQ <= 32'h0;
      cmpCntQ <= 16'h0;
    end else begin
      validQ <= stD == sqh_pkg::ST_CMPL;
      if (stD == sqh_pkg::ST_CMPL && stQ != sqh_pkg::ST_CMPL) begin
        respQ <= respD;
        statQ <= statD;
        senseQ <= senseD;
        residQ <= residD;
        cmpCntQ <= cmpCntQ + 16'h1;
      end
    end
  end

  // stream ready and drain handshake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readyQ <= 1'b0;
      drainDoneQ <= 1'b0;
      cdbByteQ <= 8'h00;
    end else begin
      readyQ <= isParse(stD) && !devDrain;
      drainDoneQ <= devDrain && stD == sqh_pkg::ST_LUN && cntD == 32'h0;
      cdbByteQ <= cdbQ[cdbRdIdx];
    end
  end

  // ----------------------------------------
  // register slave, one wait cycle per access
  // ----------------------------------------
  wire busReq = avsRead || avsWrite;
  wire wrNow = avsWrite && !waitQ;
  wire [31:0] rdMux =
    (avsAddress == `SQH_OFS_FEATURES) ? {28'h0, featQ} :
    (avsAddress == `SQH_OFS_SENSE_SIZE) ? senseSizeQ :
    (avsAddress == `SQH_OFS_CDB_SIZE) ? cdbSizeQ :
    (avsAddress == `SQH_OFS_MAX_TARGET) ? {24'h0, maxTgtQ} :
    (avsAddress == `SQH_OFS_STATE) ? {cmpCntQ, 7'h0, stQ} : 32'h0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waitQ <= 1'b1;
      rdDataQ <= 32'h0;
    end else begin
      waitQ <= !(busReq && waitQ);
      if (avsRead && waitQ) rdDataQ <= rdMux;
    end
  end

  // configuration writes; unmapped offsets are ignored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      featQ <= `SQH_FEATURES_RST;
      senseSizeQ <= `SQH_SENSE_SIZE_RST;
      cdbSizeQ <= `SQH_CDB_SIZE_RST;
      maxTgtQ <= `SQH_MAX_TARGET_RST;
    end else if (wrNow) begin
      if (avsAddress == `SQH_OFS_FEATURES) begin
        featQ <= avsWriteData[3:0];
      end else if (avsAddress == `SQH_OFS_SENSE_SIZE) begin
        senseSizeQ <= avsWriteData;
      end else if (avsAddress == `SQH_OFS_CDB_SIZE) begin
        cdbSizeQ <= avsWriteData;
      end else if (avsAddress == `SQH_OFS_MAX_TARGET) begin
        maxTgtQ <= avsWriteData[7:0];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avsReadData = rdDataQ;
  assign avsWaitRequest = waitQ;
  assign reqReady = readyQ;
  assign exeStart = startQ;
  assign exeWellKnown = wellKnown;
  assign exeTarget = lunQ[1];
  assign exeLun = {lunQ[2][5:0], lunQ[3]};
  assign exeCrn = crnQ;
  assign outgoingProtectionLength = outLenQ;
  assign incomingProtectionLength = inLenQ;
  assign exeDataOutLen = doutQ;
  assign exeDataInLen = dinQ;
  assign cdbRdByte = cdbByteQ;
  assign drainDone = drainDoneQ;
  assign cmpValid = validQ;
  assign cmpQueue = queueQ;
  assign cmpTag = tagQ;
  assign cmpResponse = respQ;
  assign cmpStatus = statQ;
  assign cmpSenseLen = senseQ;
  assign cmpResidual = residQ;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  bus_wait_a: assert property (busReq && waitQ |=> !avsWaitRequest
    ##1 avsWaitRequest) else $error("wait cycle wrong");
  bidi_fail_a: assert property (inExec && !startedQ && bidiBad && !devDrain
    |=> cmpValid && cmpResponse == 4'h9)
    else $error("bidirectional request not failed");
  bad_target_a: assert property (inExec && !startedQ && badTarget &&
    !shortQ && !bidiBad && !devDrain |=> ##1 cmpResponse == 4'h3
    && !exeStart) else $error("bad target not reported");
  sense_bound_a: assert property (cmpValid |-> cmpSenseLen <= senseSizeQ)
    else $error("sense length over size");
  overrun_resp_a: assert property (inExec && targetRan && tgtResult == 4'h0
    && overrun |=> ##1 cmpResponse == 4'h1)
    else $error("overrun not reported");
  abort_resp_a: assert property (inExec && startedQ && cancelAbort &&
    !cancelReset |=> ##1 cmpResponse == 4'h2)
    else $error("abort not reported");
  reset_resp_a: assert property (inExec && startedQ && cancelReset
    |=> ##1 cmpResponse == 4'h4) else $error("reset not reported");
  drain_fail_a: assert property (inExec && !startedQ && drainHit |=>
    cmpValid && cmpResponse == 4'h9)
    else $error("drain did not fail command");
  cmp_hold_a: assert property (cmpValid && !cmpReady |=> cmpValid &&
    $stable(cmpResponse) && $stable(cmpQueue))
    else $error("completion dropped");
  status_ok_a: assert property (inExec && targetRan && tgtResult == 4'h0
    && !overrun |=> ##1 cmpStatus == $past(tgtStatus, 2))
    else $error("status not passed");

  wk_start_c: cover property (exeStart && exeWellKnown);
  bidi_c: cover property (cmpValid && cmpResponse == 4'h9);
  ok_c: cover property (cmpValid && cmpResponse == 4'h0 && cmpReady);
  drain_c: cover property (drainDone);

endmodule
`default_nettype wire

// [design/sqh_regs.svh]
// register offsets, reset values and field codes of the request handler
`ifndef SQH_REGS_SVH
`define SQH_REGS_SVH
// register byte offsets
`define SQH_OFS_FEATURES 8'h00
`define SQH_OFS_SENSE_SIZE 8'h04
`define SQH_OFS_CDB_SIZE 8'h08
`define SQH_OFS_MAX_TARGET 8'h0C
`define SQH_OFS_STATE 8'h10
// feature bit positions
`define SQH_FEAT_INOUT_BIT 0
`define SQH_FEAT_PI_BIT 3
// reset values
`define SQH_SENSE_SIZE_RST 32'h00000060
`define SQH_CDB_SIZE_RST 32'h00000020
`define SQH_MAX_TARGET_RST 8'hFF
`define SQH_FEATURES_RST 4'h0
// command descriptor storage depth in bytes
`define SQH_CDB_DEPTH 32
// unit address forms
`define SQH_LUN_WK_B0 8'hC1
`define SQH_LUN_WK_B1 8'h01
`define SQH_LUN_FLAT_B0 8'h01
`define SQH_LUN_SINGLE_LEVEL 2'h1
// task attribute codes
`define SQH_ATTR_SIMPLE 8'h00
`define SQH_ATTR_ORDERED 8'h01
`define SQH_ATTR_CONTINGENT_ALLEGIANCE 8'h03
// response codes
`define SQH_RESP_OK 4'h0
`define SQH_RESP_OVERRUN 4'h1
`define SQH_RESP_CANCELLED_BY_ABORT 4'h2
`define SQH_RESP_BAD_TARGET 4'h3
`define SQH_RESP_RESET 4'h4
`define SQH_RESP_BUSY 4'h5
`define SQH_RESP_TRANSPORT_FAILURE 4'h6
`define SQH_RESP_TARGET_FAILURE 4'h7
`define SQH_RESP_NEXUS_FAILURE 4'h8
`define SQH_RESP_FAILURE 4'h9
`endif

// [design/sqh_pkg.sv]
// types shared by the request handler
package sqh_pkg;
  // parser and completion states, one-hot
  typedef enum logic [8:0] {
    ST_LUN = 9'h001,
    ST_TAG = 9'h002,
    ST_ATTR = 9'h004,
    ST_CDB = 9'h008,
    ST_PILEN = 9'h010,
    ST_PIOUT = 9'h020,
    ST_DOUT = 9'h040,
    ST_EXEC = 9'h080,
    ST_CMPL = 9'h100
  } sqh_state_e;
endpackage

// [dv/sqh_driver_model.sv]
// guest-side request source and completion sink for the handler
`timescale 1ns/100ps
`default_nettype none
module sqh_driver_model (
  input wire logic core_clk,
  input wire logic reqReady,
  output logic reqValid,
  output logic [7:0] reqData,
  output logic reqLast,
  output logic [3:0] reqQueue,
  output logic [31:0] reqInLen,
  output logic cmpReady
);
  logic [1:0] stall_q = 2'h0;

  // quiet stream at time zero
  initial begin
    reqValid = 1'b0;
    reqData = 8'h5A;
    reqLast = 1'b0;
    reqQueue = 4'h0;
    reqInLen = 32'h0;
  end

  // completion sink takes one of four cycles, so cmpValid must hold
  always @(posedge core_clk) begin
    stall_q <= stall_q + 2'h1;
    cmpReady <= (stall_q == 2'h2);
  end

  // one request, each byte held until the edge that takes it
  task automatic send(input logic [7:0] bytes[$], input logic [3:0] q,
                      input logic [31:0] inLen);
    @(posedge core_clk);
    reqQueue <= q;
    reqInLen <= inLen;
    foreach (bytes[i]) begin
      reqValid <= 1'b1;
      reqData <= bytes[i];
      reqLast <= (i == bytes.size() - 1);
      @(posedge core_clk iff reqReady === 1'b1);
    end
    reqValid <= 1'b0;
    reqLast <= 1'b0;
    reqData <= ~reqData; // released line must not echo the last byte
  endtask
endmodule
`default_nettype wire

// [dv/scsi_request_queue_handler_tb_top.sv]
// self-checking bench of the request queue handler
`timescale 1ns/100ps
`default_nettype none
module scsi_request_queue_handler_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0, nrst = 1'b0;
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'b0, avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0, avsReadData;
  logic avsWaitRequest, reqValid, reqLast, reqReady, cmpReady;
  logic [7:0] reqData, exeTarget, exeCrn, cdbRdByte, cmpStatus;
  logic [3:0] reqQueue, cmpQueue, cmpResponse;
  logic [31:0] reqInLen, outLen, inLen, exeDataOutLen, exeDataInLen;
  logic exeStart, exeWellKnown, drainDone, cmpValid;
  logic [13:0] exeLun;
  logic [4:0] cdbRdIdx = 5'h00;
  logic tgtDone = 1'b0, cancelAbort = 1'b0, cancelReset = 1'b0;
  logic devDrain = 1'b0;
  logic [3:0] tgtResult = 4'h0;
  logic [7:0] tgtStatus = 8'h00, attrSel = 8'h00;
  logic [31:0] tgtSenseLen = 32'h0, tgtNeed = 32'h0, tgtXfer = 32'h0;
  logic [63:0] cmpTag;
  logic [31:0] cmpSenseLen, cmpResidual, rd, rnd = 32'h1D55;
  int miscompares = 0, comparisons = 0, cdbSize = 32;
  logic piOn = 1'b0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  sqh_request_handler sqh_request_handler_inst (.core_clk(core_clk),
    .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .reqValid(reqValid), .reqData(reqData), .reqLast(reqLast),
    .reqQueue(reqQueue), .reqInLen(reqInLen), .reqReady(reqReady),
    .exeStart(exeStart), .exeWellKnown(exeWellKnown),
    .exeTarget(exeTarget), .exeLun(exeLun), .exeCrn(exeCrn),
    .outgoingProtectionLength(outLen), .incomingProtectionLength(inLen),
    .exeDataOutLen(exeDataOutLen), .exeDataInLen(exeDataInLen),
    .cdbRdIdx(cdbRdIdx), .cdbRdByte(cdbRdByte), .tgtDone(tgtDone),
    .tgtResult(tgtResult), .tgtStatus(tgtStatus),
    .tgtSenseLen(tgtSenseLen), .tgtNeed(tgtNeed), .tgtXfer(tgtXfer),
    .cancelAbort(cancelAbort), .cancelReset(cancelReset),
    .devDrain(devDrain), .drainDone(drainDone), .cmpReady(cmpReady),
    .cmpValid(cmpValid), .cmpQueue(cmpQueue), .cmpTag(cmpTag),
    .cmpResponse(cmpResponse), .cmpStatus(cmpStatus),
    .cmpSenseLen(cmpSenseLen), .cmpResidual(cmpResidual));

  sqh_driver_model sqh_driver_model_inst (.core_clk(core_clk),
    .reqReady(reqReady), .reqValid(reqValid), .reqData(reqData),
    .reqLast(reqLast), .reqQueue(reqQueue), .reqInLen(reqInLen),
    .cmpReady(cmpReady));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // sense length is clipped to the default sense size of 96
  function automatic logic [31:0] expSense(input logic [31:0] l);
    return (l > 32'h60) ? 32'h60 : l;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // avalon master: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge core_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= wd;
    @(posedge core_clk iff avsWaitRequest === 1'b0);
    r = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  // one command; mode 0 done, 1 refused, 2 abort, 3 reset, 4 drain
  task automatic run_cmd(input logic [31:0] addr, input logic [7:0] crn,
    input logic [31:0] dout, din, need, input logic [3:0] mode, res, resp);
    logic [7:0] b[$];
    logic [63:0] tag;
    logic [31:0] xf;
    rnd = lfsr(rnd);
    tag[31:0] = rnd;
    rnd = lfsr(rnd);
    tag[63:32] = rnd;
    xf = rnd % (dout + din + 1);
    b = {addr[31:24], addr[23:16], addr[15:8], addr[7:0], 8'h00, 8'h00,
         8'h00, 8'h00};
    for (int i = 0; i < 8; i++) b.push_back(tag[8*i +: 8]);
    b = {b, attrSel, 8'h00, crn};
    for (int i = 0; i < cdbSize; i++) b.push_back(8'(8'hA0 + i));
    if (piOn) b = {b, 8'h02, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00,
                   8'h00, 8'hEE, 8'hEE};
    for (int i = 0; i < dout; i++) b.push_back(8'(i));
    sqh_driver_model_inst.send(b, rnd[3:0], din);
    if (mode != 4'h1) begin
      @(posedge core_clk iff exeStart === 1'b1);
      check(exeWellKnown, addr[31:16] == 16'hC101);
      if (addr[31:24] == 8'h01) begin
        check(exeTarget, addr[23:16]);
        check(exeLun, addr[13:0]);
      end
      check(exeCrn, crn);
      check(exeDataOutLen, dout);
      check(exeDataInLen, din);
      check(outLen, piOn ? 32'h2 : 32'h0);
      check(inLen, piOn ? 32'h5 : 32'h0);
      cdbRdIdx <= 5'h01;
      repeat (2) @(posedge core_clk);
      check(cdbRdByte, 8'hA1);
      case (mode)
        4'h0: begin
          tgtResult <= res;
          tgtStatus <= rnd[15:8];
          tgtSenseLen <= rnd[23:16];
          tgtNeed <= need;
          tgtXfer <= xf;
          tgtDone <= 1'b1;
        end
        4'h2: cancelAbort <= 1'b1;
        4'h3: cancelReset <= 1'b1;
        default: devDrain <= 1'b1;
      endcase
      @(posedge core_clk);
      tgtDone <= 1'b0;
      cancelAbort <= 1'b0;
      cancelReset <= 1'b0;
    end
    @(posedge core_clk iff (cmpValid === 1'b1 && cmpReady === 1'b1));
    check(cmpResponse, resp);
    check(cmpQueue, rnd[3:0]);
    check(cmpTag, tag);
    if (resp == 4'h0) begin
      check(cmpStatus, rnd[15:8]);
      check(cmpSenseLen, expSense(rnd[23:16]));
    end
    if (mode == 4'h0) check(cmpResidual, dout + din - xf);
    if (mode == 4'h1) check(cmpResidual, dout + din);
    devDrain <= 1'b0;
    if (mode == 4'h4) begin
      @(posedge core_clk);
      check(drainDone, 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    bus(1'b0, 8'h04, 32'h0, rd);
    check(rd, 32'h60);
    bus(1'b0, 8'h08, 32'h0, rd);
    check(rd, 32'h20);
    bus(1'b0, 8'h3C, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, 8'h08, 32'h6, rd);
    cdbSize = 6;
    done("registers");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      attrSel = (i == 1) ? 8'h01 : (i == 2) ? 8'h03 : 8'h00;
      run_cmd({8'h01, rnd[7:0], 2'h1, rnd[21:8]}, (i == 0) ? 8'hFF :
              rnd[31:24], 32'(rnd[2:0]), 0, 0, 0, 0, 0);
    end
    attrSel = 8'h00;
    done("random");
    run_cmd(32'h01054007, 0, 3, 0, 4, 0, 0, 1);
    for (int r = 5; r <= 8; r++)
      run_cmd(32'h01054007, 0, 2, 0, 0, 0, 4'(r), 4'(r));
    run_cmd(32'hC1010000, 0, 1, 0, 0, 0, 0, 0);
    run_cmd(32'h02054007, 0, 1, 0, 0, 1, 0, 3);
    bus(1'b1, 8'h0C, 32'h3, rd);
    run_cmd(32'h01044001, 0, 1, 0, 0, 1, 0, 3);
    run_cmd(32'h01034001, 0, 1, 0, 0, 0, 0, 0);
    bus(1'b1, 8'h0C, 32'hFF, rd);
    done("addressing");
    run_cmd(32'h01054007, 0, 2, 3, 0, 1, 0, 9);
    bus(1'b1, 8'h00, 32'h1, rd);
    run_cmd(32'h01054007, 0, 2, 3, 0, 0, 0, 0);
    bus(1'b1, 8'h00, 32'h8, rd);
    piOn = 1'b1;
    run_cmd(32'h01054007, 0, 1, 0, 0, 0, 0, 0);
    bus(1'b1, 8'h00, 32'h0, rd);
    piOn = 1'b0;
    done("features");
    run_cmd(32'h01054007, 0, 2, 0, 0, 2, 0, 2);
    run_cmd(32'h01054007, 0, 2, 0, 0, 3, 0, 4);
    run_cmd(32'h01054007, 0, 2, 0, 0, 4, 0, 9);
    done("cancel");
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    bus(1'b0, 8'h08, 32'h0, rd);
    check(rd, 32'h20);
    done("second reset");
    stop_test;
  end

  // watchdog far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
